// ===== logic/sfma_pkg.sv
// shared constants and carriers for the secondary fault mask aggregator
// assumes one 25 MHz logic clock and a synchronous active-high reset
package sfma_pkg;

    // ==========================================================
    // register map
    localparam logic [4:0] SFMA_MASK_ADDR = 5'h0e;

    // ==========================================================
    // secondary_fault_mask fields
    localparam int SFMA_DIE_LSB = 5;
    localparam int SFMA_ASL_BIT = 4;
    localparam int SFMA_CCE_BIT = 3;
    localparam int SFMA_TSD_BIT = 2;
    localparam int SFMA_ROP_BIT = 1;
    localparam int SFMA_RSH_BIT = 0;
    // only thermal_shutdown_block comes out of reset set
    localparam logic [4:0] SFMA_MASK_RESET = 5'h04;
    // arbitrary value, not tied to any real part
    localparam logic [2:0] SFMA_DIE_CODE_DEF = 3'h5;

    // ==========================================================
    // serial frame lengths in clocks
    localparam logic [4:0] SFMA_FRAME_PLAIN = 5'h10;
    localparam logic [4:0] SFMA_FRAME_CRC = 5'h18;
    localparam int SFMA_SR_W = 24;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic write;
        logic [1:0] chip;
        logic [4:0] addr;
        logic [7:0] data;
    } sfma_cmd_s;

    typedef struct packed {
        logic analog_supply_low;
        logic clock_count_error;
        logic thermal_shutdown_flag;
        logic reference_open_flag;
        logic reference_short_flag;
    } sfma_src_s;

    typedef enum logic {
        SFMA_IDLE,
        SFMA_SHIFT
    } sfma_state_e;

endpackage : sfma_pkg

// ===== logic/sfma_mask_core.sv
// mask register and masked OR that forms secondary_alarm_summary
// assumes writes arrive as one-cycle strobes from the frame engine
`timescale 1ns/1ps
module sfma_mask_core #(
    parameter logic [2:0] DIE_CODE = sfma_pkg::SFMA_DIE_CODE_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register write
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    // fault sources
    input wire sfma_pkg::sfma_src_s src_i,
    // results
    output logic [7:0] mask_o,
    output logic summary_o
);
    logic [4:0] mask_r;
    logic [4:0] mask_nxt;
    logic summary_r;
    logic summary_nxt;

    // ==========================================================
    // register and summary
    always_comb begin
        mask_nxt = mask_r;
        if (wr_i) begin
            mask_nxt = wr_data_i[4:0];
        end
        summary_nxt = |(src_i & ~mask_r);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mask_r <= sfma_pkg::SFMA_MASK_RESET;
            summary_r <= 1'b0;
        end else begin
            mask_r <= mask_nxt;
            summary_r <= summary_nxt;
        end
    end

    // die code is fixed, writes to it go nowhere
    assign mask_o = {DIE_CODE, mask_r};
    assign summary_o = summary_r;

    // ==========================================================
    // checks
    property p_summary_or;
        @(posedge clk_i) disable iff (sys_rst_i)
        ##1 summary_o == |($past(src_i) & ~$past(mask_r));
    endproperty
    a_summary_or: assert property (p_summary_or) else $error("summary not masked OR");

    property p_asl;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!mask_r[sfma_pkg::SFMA_ASL_BIT] && src_i.analog_supply_low) |=> summary_o;
    endproperty
    a_asl: assert property (p_asl) else $error("unmasked supply low ignored");

    property p_cce;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mask_r[sfma_pkg::SFMA_CCE_BIT] && $changed(src_i.clock_count_error)
            && (src_i & ~mask_r) == 5'h00) |=> !summary_o;
    endproperty
    a_cce: assert property (p_cce) else $error("masked clock error leaked");

    property p_tsd;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mask_r[sfma_pkg::SFMA_TSD_BIT] && src_i == 5'h04) |=> !summary_o;
    endproperty
    a_tsd: assert property (p_tsd) else $error("masked thermal leaked");

    property p_rop;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!mask_r[sfma_pkg::SFMA_ROP_BIT] && src_i.reference_open_flag) ##1 1'b1 |-> summary_o;
    endproperty
    a_rop: assert property (p_rop) else $error("unmasked open ignored");

    property p_rsh;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mask_r[sfma_pkg::SFMA_RSH_BIT] && src_i == 5'h01) |=> !summary_o;
    endproperty
    a_rsh: assert property (p_rsh) else $error("masked short leaked");

    property p_die_reset;
        @(posedge clk_i)
        sys_rst_i |=> (mask_o == {DIE_CODE, sfma_pkg::SFMA_MASK_RESET});
    endproperty
    a_die_reset: assert property (p_die_reset) else $error("bad reset or die code");

endmodule : sfma_mask_core

// ===== logic/sfma_top.sv
// serial frame engine plus secondary fault mask aggregator
// assumes serial pins are already synchronous to clk_i and sclk is far slower than clk_i
`timescale 1ns/1ps
module sfma_top #(
    parameter int ADDR_DEVICES = 4,
    parameter logic [2:0] DIE_CODE = sfma_pkg::SFMA_DIE_CODE_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // serial port
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // straps and mode
    input wire logic [1:0] chip_addr_i,
    input wire logic chain_mode_i,
    input wire logic crc_en_i,
    // fault sources
    input wire logic analog_supply_low_i,
    input wire logic thermal_shutdown_flag_i,
    input wire logic reference_open_flag_i,
    input wire logic reference_short_flag_i,
    input wire logic clock_count_error_clr_i,
    // results
    output logic clock_count_error_o,
    output logic secondary_alarm_summary_o,
    output logic [7:0] secondary_fault_mask_o
);
    generate
        if (ADDR_DEVICES < 1 || ADDR_DEVICES > 4) begin : g_bad_devices
            $error("ADDR_DEVICES must be 1 to 4");
        end
    endgenerate

    // ==========================================================
    // helpers
    function automatic logic [4:0] frame_len(input logic crc);
        return crc ? sfma_pkg::SFMA_FRAME_CRC : sfma_pkg::SFMA_FRAME_PLAIN;
    endfunction : frame_len

    function automatic logic top_bit(input logic [23:0] sr, input logic crc);
        return crc ? sr[23] : sr[15];
    endfunction : top_bit

    // ==========================================================
    // state
    sfma_pkg::sfma_state_e state_r, state_nxt;
    logic [23:0] sr_r, sr_nxt;
    logic [4:0] pos_r, pos_nxt;
    logic [1:0] frames_r, frames_nxt;
    logic sclk_d_r, sclk_d_nxt;
    logic sdo_r, sdo_nxt;
    logic [7:0] reply_r, reply_nxt;
    logic cce_r, cce_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic [7:0] mask_rd;
    logic sclk_rise;
    logic frame_end;
    logic count_ok;
    logic addr_ok;
    sfma_pkg::sfma_cmd_s cmd;
    sfma_pkg::sfma_src_s src;

    assign sclk_rise = sclk_i && !sclk_d_r;
    assign frame_end = (state_r == sfma_pkg::SFMA_SHIFT) && cs_n_i;
    assign cmd = crc_en_i ? sr_r[23:8] : sr_r[15:0];
    // a multiple of the frame length is accepted in a chain, exactly one otherwise
    assign count_ok = (pos_r == 5'h00) && (frames_r != 2'h0)
                      && (chain_mode_i || frames_r == 2'h1);
    // outside chain mode, addresses at or above the configured device count never match
    assign addr_ok = chain_mode_i
                     || (cmd.chip == chip_addr_i && 32'(chip_addr_i) < ADDR_DEVICES);

    // ==========================================================
    // frame engine
    always_comb begin
        state_nxt = state_r;
        sr_nxt = sr_r;
        pos_nxt = pos_r;
        frames_nxt = frames_r;
        sclk_d_nxt = sclk_i;
        sdo_nxt = sdo_r;
        reply_nxt = reply_r;
        cce_nxt = cce_r;
        wr_nxt = 1'b0;
        wr_data_nxt = wr_data_r;
        if (clock_count_error_clr_i) begin
            cce_nxt = 1'b0;
        end
        case (state_r)
            sfma_pkg::SFMA_IDLE: begin
                if (!cs_n_i) begin
                    // last read answer goes out in the second byte of this frame, after eight zero bits
                    sr_nxt = crc_en_i ? {8'h00, reply_r, 8'h00} : {8'h00, 8'h00, reply_r};
                    sdo_nxt = 1'b0;
                    pos_nxt = 5'h00;
                    frames_nxt = 2'h0;
                    state_nxt = sfma_pkg::SFMA_SHIFT;
                end
            end
            sfma_pkg::SFMA_SHIFT: begin
                if (cs_n_i) begin
                    state_nxt = sfma_pkg::SFMA_IDLE;
                    if (!count_ok) begin
                        cce_nxt = 1'b1;
                    end else if (addr_ok) begin
                        reply_nxt = (cmd.addr == sfma_pkg::SFMA_MASK_ADDR) ? mask_rd : 8'h00;
                        if (cmd.write && cmd.addr == sfma_pkg::SFMA_MASK_ADDR) begin
                            wr_nxt = 1'b1;
                            wr_data_nxt = cmd.data;
                        end
                    end
                end else if (sclk_rise) begin
                    sr_nxt = {sr_r[22:0], sdi_i};
                    sdo_nxt = top_bit({sr_r[22:0], sdi_i}, crc_en_i);
                    if (pos_r == frame_len(crc_en_i) - 5'h01) begin
                        pos_nxt = 5'h00;
                        frames_nxt = (frames_r == 2'h2) ? 2'h2 : frames_r + 2'h1;
                    end else begin
                        pos_nxt = pos_r + 5'h01;
                    end
                end else if (state_r == sfma_pkg::SFMA_SHIFT && pos_r == 5'h00
                             && frames_r == 2'h0) begin
                    sdo_nxt = top_bit(sr_r, crc_en_i);
                end
            end
            default: state_nxt = sfma_pkg::SFMA_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= sfma_pkg::SFMA_IDLE;
            sr_r <= 24'h00_0000;
            pos_r <= 5'h00;
            frames_r <= 2'h0;
            sclk_d_r <= 1'b0;
            sdo_r <= 1'b0;
            reply_r <= 8'h00;
            cce_r <= 1'b0;
            wr_r <= 1'b0;
            wr_data_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sr_r <= sr_nxt;
            pos_r <= pos_nxt;
            frames_r <= frames_nxt;
            sclk_d_r <= sclk_d_nxt;
            sdo_r <= sdo_nxt;
            reply_r <= reply_nxt;
            cce_r <= cce_nxt;
            wr_r <= wr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // ==========================================================
    // mask and summary
    assign src = '{analog_supply_low: analog_supply_low_i,
                   clock_count_error: cce_r,
                   thermal_shutdown_flag: thermal_shutdown_flag_i,
                   reference_open_flag: reference_open_flag_i,
                   reference_short_flag: reference_short_flag_i};

    sfma_mask_core #(
        .DIE_CODE(DIE_CODE)
    ) u_core (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_r),
        .wr_data_i(wr_data_r),
        .src_i(src),
        .mask_o(mask_rd),
        .summary_o(secondary_alarm_summary_o)
    );

    assign sdo_o = sdo_r;
    assign sdo_oe_o = (state_r == sfma_pkg::SFMA_SHIFT);
    assign clock_count_error_o = cce_r;
    assign secondary_fault_mask_o = mask_rd;

    // ==========================================================
    // checks
    sequence s_bad_end;
        frame_end && !count_ok;
    endsequence

    property p_discard;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_bad_end |=> (clock_count_error_o && !wr_r);
    endproperty
    a_discard: assert property (p_discard) else $error("bad frame not dropped");

    property p_addr;
        @(posedge clk_i) disable iff (sys_rst_i)
        (frame_end && !chain_mode_i && cmd.chip != chip_addr_i) |=> !wr_r;
    endproperty
    a_addr: assert property (p_addr) else $error("foreign address accepted");

    property p_set_wins;
        @(posedge clk_i) disable iff (sys_rst_i)
        (s_bad_end ##0 clock_count_error_clr_i) |=> clock_count_error_o;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat error set");

endmodule : sfma_top

// ===== tb/sfma_spi_ctrl.sv
// serial controller model standing on the far side of the aggregator
// assumes clk_i is the device logic clock; pins change on its falling edge
`timescale 1ns/1ps
module sfma_spi_ctrl (
    // clock
    input wire logic clk_i,
    // serial pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    // ==========================================================
    // frame driver
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // each sclk phase spans two clocks so the edge detector sees it
    task automatic xfer(input int n, input logic [47:0] w, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk_i) cs_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = w[i];
            rx = {rx[14:0], sdo_i};
            repeat (2) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (2) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        cs_n_o = 1'b1;
        // a released data line must not look like a held bit
        sdi_o = ~sdi_o;
        repeat (4) @(negedge clk_i);
    endtask : xfer
endmodule : sfma_spi_ctrl

// ===== tb/sfma_top_tb_top.sv
// self-checking bench for the secondary fault mask aggregator
// assumes the default die code and four addressable devices
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module sfma_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sclk, sdi, sdo, sdo_oe, chain, crc, clr, cce, summ;
    logic [1:0] chip = 2'h2;
    logic [4:0] src = 5'h00;
    logic [7:0] mask;
    logic [15:0] rx;
    int errors = 0;
    int total_checks = 0;
    // ==========================================================
    // clock, model and device
    always #20 clk = ~clk;
    sfma_spi_ctrl i_ctrl (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo));
    sfma_top i_dut (.clk_i(clk), .sys_rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .chip_addr_i(chip),
        .chain_mode_i(chain), .crc_en_i(crc), .analog_supply_low_i(src[4]),
        .thermal_shutdown_flag_i(src[2]), .reference_open_flag_i(src[1]),
        .reference_short_flag_i(src[0]), .clock_count_error_clr_i(clr),
        .clock_count_error_o(cce), .secondary_alarm_summary_o(summ),
        .secondary_fault_mask_o(mask));
    // ==========================================================
    // helpers
    function automatic logic [15:0] cmd(logic w, logic [1:0] c, logic [4:0] a,
        logic [7:0] d);
        return {w, c, a, d};
    endfunction : cmd
    task automatic wr(input logic [7:0] d, input logic [1:0] c, input logic [4:0] a);
        i_ctrl.xfer(16, {32'h0000_0000, cmd(1'b1, c, a, d)}, rx);
    endtask : wr
    task automatic put_src(input logic [4:0] s);
        @(negedge clk) src = s;
        repeat (2) @(negedge clk);
    endtask : put_src
    task automatic clear_err;
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        `CHK(cce, 1'b0)
    endtask : clear_err
    // ==========================================================
    // scenarios
    task automatic t_reset;
        `CHK(mask, 8'ha4)
        `CHK({summ, cce, sdo_oe}, 3'h0)
        $display("test reset done");
    endtask : t_reset
    task automatic t_sources;
        logic [4:0] b;
        for (int i = 0; i < 5; i++) begin
            b = 5'h01 << i;
            if (i == 3) continue;
            wr({3'h0, 5'h1f ^ b}, chip, 5'h0e);
            `CHK(summ, 1'b0)
            put_src(b);
            `CHK(summ, 1'b1)
            wr(8'h1f, chip, 5'h0e);
            `CHK(summ, 1'b0)
            put_src(5'h00);
            `CHK(summ, 1'b0)
        end
        wr(8'h00, chip, 5'h0e);
        put_src(5'h11);
        put_src(5'h10);
        `CHK(summ, 1'b1)
        put_src(5'h00);
        `CHK(summ, 1'b0)
        $display("test sources done");
    endtask : t_sources
    task automatic t_ccount;
        wr(8'h17, chip, 5'h0e);
        // a clear that lands on the closing edge of a bad frame must lose
        fork
            i_ctrl.xfer(15, {32'h0, cmd(1'b1, chip, 5'h0e, 8'h00)}, rx);
            begin
                @(posedge cs_n);
                `CHK(sdo_oe, 1'b1)
                clr = 1'b1;
                @(negedge clk) clr = 1'b0;
            end
        join
        `CHK(mask, 8'hb7)
        `CHK({cce, summ}, 2'h3)
        wr(8'h1f, chip, 5'h0e);
        `CHK(summ, 1'b0)
        clear_err();
        $display("test clock count done");
    endtask : t_ccount
    task automatic t_die_ro;
        wr(8'hff, chip, 5'h0e);
        `CHK(mask, 8'hbf)
        i_ctrl.xfer(16, {32'h0, cmd(1'b0, chip, 5'h0e, 8'h00)}, rx);
        i_ctrl.xfer(16, {32'h0, cmd(1'b0, chip, 5'h0e, 8'h00)}, rx);
        `CHK(rx, 16'h00bf)
        $display("test die code done");
    endtask : t_die_ro
    task automatic t_addr;
        wr(8'h00, chip ^ 2'h1, 5'h0e);
        `CHK(mask, 8'hbf)
        wr(8'h00, chip, 5'h0d);
        `CHK(mask, 8'hbf)
        $display("test address done");
    endtask : t_addr
    task automatic t_chain;
        @(negedge clk) chain = 1'b1;
        crc = 1'b1;
        i_ctrl.xfer(48, {24'h0, cmd(1'b1, chip, 5'h0e, 8'h04), 8'h00}, rx);
        `CHK(mask, 8'ha4)
        i_ctrl.xfer(40, {16'h0, cmd(1'b1, chip, 5'h0e, 8'h00), 8'h00}, rx);
        `CHK({cce, mask}, 9'h1a4)
        clear_err();
        @(negedge clk) chain = 1'b0;
        i_ctrl.xfer(24, {24'h0, cmd(1'b1, chip, 5'h0e, 8'h11), 8'h00}, rx);
        `CHK(mask, 8'hb1)
        @(negedge clk) crc = 1'b0;
        chain = 1'b1;
        i_ctrl.xfer(32, {16'h0, 16'h0, cmd(1'b1, chip, 5'h0e, 8'h1f)}, rx);
        `CHK(mask, 8'hbf)
        @(negedge clk) chain = 1'b0;
        $display("test chain done");
    endtask : t_chain
    // ==========================================================
    // run control
    task automatic conclude;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        chain = 1'b0;
        crc = 1'b0;
        clr = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        // field supply low and its block sit in the primary enables, outside this block
        t_reset();
        t_sources();
        t_ccount();
        t_die_ro();
        t_addr();
        t_chain();
        conclude();
    end
    // whole run is near 1860 cycles
    initial begin
        #(40 * 30000);
        errors++;
        conclude();
    end
endmodule : sfma_top_tb_top
